// *** hw/fdp_port.sv ***
// Drive-side control port: select, spindle, stepping, recording, surface
//
// Overview of operation
// - Low level means asserted unless stated otherwise.
// - Honour inputs, drive outputs only while selected; spindle run is honoured regardless of select.
// - Spindle reaches rated speed within 480ms.
// - Direction high steps outward, low steps inward.
// - Step low 0.8us; one track per step.
// - Move starts at step rise, done 18ms.
// - Ignore steps when writing, at limits.
// - Write mode needs gate, select, unlocked media.
// - Record pulse falling edge is the data event.
// - Drop record pulses ungated or media locked.
// - Surface high selects side 0, low side 1.
// - Playback valid only 100us after surface change.
// - Outermost flag asserted while head on track zero.
// - Media lock flag asserted while hole open.
`timescale 1ns/100ps
`default_nettype none
module fdp_port
    import fdp_pkg::*;
#(
    parameter logic [SPIN_W-1:0] SPIN_UP_CNT = SPIN_W'(SPIN_UP_CYC),
    parameter logic [SEEK_W-1:0] SEEK_CNT    = SEEK_W'(SEEK_SETTLE_CYC)
) (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire fdp_host_in_type    host_in,
    input  wire logic               hole_open,
    output logic                    outermost_n,
    output logic                    media_lock_n,
    output logic                    spindle_on,
    output logic                    spindle_ready,
    output logic                    head_step,
    output logic                    head_outward,
    output logic [TRACK_W-1:0]      track,
    output logic                    seek_busy,
    output logic                    write_mode,
    output logic                    rec_event,
    output logic                    head_upper,
    output logic                    playback_valid
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    fdp_host_in_type  hs;
    logic [HOST_W-1:0] hs_raw;

    // Every host line passes two flops before edge detection
    fdp_sync u_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (host_in),
        .sync_out (hs_raw)
    );
    assign hs = fdp_host_in_type'(hs_raw);

    // Decoded true levels; low is asserted on the host lines, hole_open is high true
    logic sel;
    logic spin;
    logic gate;
    logic locked;
    assign sel    = !hs.sel_n;
    assign spin   = !hs.spin_n;
    assign gate   = !hs.gate_n;
    assign locked = hole_open;

    // ------------------------------------------------------------------
    // Edge detection state
    // ------------------------------------------------------------------
    logic step_prev_q;
    logic rec_prev_q;
    logic step_rise;
    logic rec_fall;

    // Previous values kept here so the sync's first stage stays private
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            step_prev_q <= 1'b1;
            rec_prev_q  <= 1'b1;
        end else begin
            step_prev_q <= hs.step_n;
            rec_prev_q  <= hs.rec_n;
        end
    end
    assign step_rise = !step_prev_q && hs.step_n;   // Trailing edge
    assign rec_fall  = rec_prev_q && !hs.rec_n;     // Leading edge

    // ------------------------------------------------------------------
    // Stepping, track counter and seek timer
    // ------------------------------------------------------------------
    logic               step_ok;
    logic               head_step_q, head_step_d;
    logic               head_out_q,  head_out_d;
    logic [TRACK_W-1:0] track_q,     track_d;
    logic [SEEK_W-1:0]  seek_cnt_q,  seek_cnt_d;

    // Steps are taken only while selected and no ignore case holds
    always_comb begin
        step_ok = step_rise && sel;
        if (gate && !locked) begin
            step_ok = 1'b0;
        end
        if (track_q == TRACK_ZERO && hs.dir) begin
            step_ok = 1'b0;
        end
        if (track_q == TRACK_INNER && !hs.dir) begin
            step_ok = 1'b0;
        end
        head_step_d = step_ok;
        head_out_d  = head_out_q;
        track_d     = track_q;
        seek_cnt_d  = (seek_cnt_q != '0) ? seek_cnt_q - 1'b1 : seek_cnt_q;
        if (step_ok) begin
            head_out_d = hs.dir;
            // One track per accepted pulse, never past either limit
            track_d    = hs.dir ? track_q - 1'b1 : track_q + 1'b1;
            // A fresh step restarts the settle window
            seek_cnt_d = SEEK_CNT;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            head_step_q <= 1'b0;
            head_out_q  <= 1'b1;
            track_q     <= TRACK_ZERO;   // Recalibrated to track zero at power up
            seek_cnt_q  <= '0;
        end else begin
            head_step_q <= head_step_d;
            head_out_q  <= head_out_d;
            track_q     <= track_d;
            seek_cnt_q  <= seek_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Spindle control
    // ------------------------------------------------------------------
    fdp_spin_state_type spin_st_q, spin_st_d;
    logic [SPIN_W-1:0]  spin_cnt_q, spin_cnt_d;

    // Spindle run is honoured regardless of select
    always_comb begin
        spin_st_d  = spin_st_q;
        spin_cnt_d = spin_cnt_q;
        case (spin_st_q)
            SP_STOP: begin
                spin_cnt_d = '0;
                if (spin) begin
                    spin_st_d = SP_ACCEL;
                end
            end
            SP_ACCEL: begin
                spin_cnt_d = spin_cnt_q + 1'b1;
                if (!spin) begin
                    spin_st_d = SP_STOP;
                end else if (spin_cnt_q >= SPIN_UP_CNT - 1'b1) begin
                    spin_st_d = SP_RUN;
                end
            end
            SP_RUN: begin
                if (!spin) begin
                    spin_st_d = SP_STOP;
                end
            end
            default: begin
                spin_st_d = SP_STOP;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            spin_st_q  <= SP_STOP;
            spin_cnt_q <= '0;
        end else begin
            spin_st_q  <= spin_st_d;
            spin_cnt_q <= spin_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Surface selection and playback settle
    // ------------------------------------------------------------------
    logic              upper_q,    upper_d;
    logic [SURF_W-1:0] surf_cnt_q, surf_cnt_d;
    logic              play_q,     play_d;

    // Surface line is latched only while selected; a change reloads the timer
    always_comb begin
        upper_d    = sel ? !hs.surf : upper_q;
        surf_cnt_d = (surf_cnt_q != '0) ? surf_cnt_q - 1'b1 : surf_cnt_q;
        if (upper_d != upper_q) begin
            surf_cnt_d = SURF_SETTLE_CYC;
        end
        // Stays low through the whole count, so valid comes strictly after it
        play_d = (surf_cnt_d == '0) && (upper_d == upper_q);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            upper_q    <= 1'b0;
            surf_cnt_q <= '0;
            play_q     <= 1'b0;
        end else begin
            upper_q    <= upper_d;
            surf_cnt_q <= surf_cnt_d;
            play_q     <= play_d;
        end
    end

    // ------------------------------------------------------------------
    // Write qualification, record pulses and status flags
    // ------------------------------------------------------------------
    logic wr_q,   wr_d;
    logic rev_q,  rev_d;
    logic zero_n_q, zero_n_d;
    logic lock_n_q, lock_n_d;

    // Current-cycle qualification, so a locked disk blocks the first pulse too
    always_comb begin
        wr_d     = gate && sel && !locked;
        rev_d    = rec_fall && wr_d;
        // Status flags float false while the unit is not selected
        zero_n_d = !(sel && track_q == TRACK_ZERO);
        lock_n_d = !(sel && locked);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_q     <= 1'b0;
            rev_q    <= 1'b0;
            zero_n_q <= 1'b1;
            lock_n_q <= 1'b1;
        end else begin
            wr_q     <= wr_d;
            rev_q    <= rev_d;
            zero_n_q <= zero_n_d;
            lock_n_q <= lock_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign outermost_n    = zero_n_q;
    assign media_lock_n   = lock_n_q;
    assign spindle_on     = (spin_st_q != SP_STOP);
    assign spindle_ready  = (spin_st_q == SP_RUN);
    assign head_step      = head_step_q;
    assign head_outward   = head_out_q;
    assign track          = track_q;
    assign seek_busy      = (seek_cnt_q != '0);
    assign write_mode     = wr_q;
    assign rec_event      = rev_q;
    assign head_upper     = upper_q;
    assign playback_valid = play_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_step_dir;
        @(posedge clock) disable iff (!nrst)
        step_ok |=> head_step_q && (head_out_q == $past(hs.dir));
    endproperty
    a_step_dir: assert property (p_step_dir) else $error("step direction wrong");

    property p_one_track;
        @(posedge clock) disable iff (!nrst)
        step_ok |=> (track_q == ($past(hs.dir) ? $past(track_q) - 7'h01
                                               : $past(track_q) + 7'h01));
    endproperty
    a_one_track: assert property (p_one_track) else $error("track not moved by one");

    property p_limits;
        @(posedge clock) disable iff (!nrst)
        (step_rise && ((track_q == TRACK_ZERO && hs.dir) ||
                       (track_q == TRACK_INNER && !hs.dir)))
        |=> !head_step_q && $stable(track_q);
    endproperty
    a_limits: assert property (p_limits) else $error("limit step not ignored");

    property p_gate_block;
        @(posedge clock) disable iff (!nrst)
        (gate && !locked) |=> !head_step_q;
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("step during write");

    property p_seek_hold;
        @(posedge clock) disable iff (!nrst)
        step_ok |=> seek_busy [*8];
    endproperty
    a_seek_hold: assert property (p_seek_hold) else $error("seek ended early");

    property p_write_lock;
        @(posedge clock) disable iff (!nrst)
        (locked || !sel) |=> !write_mode ##0 !rec_event;
    endproperty
    a_write_lock: assert property (p_write_lock) else $error("write while locked");

    property p_rec_drop;
        @(posedge clock) disable iff (!nrst)
        rec_event |-> $past(gate) && !$past(locked) && $past(rec_prev_q);
    endproperty
    a_rec_drop: assert property (p_rec_drop) else $error("record pulse not qualified");

    property p_surf_settle;
        @(posedge clock) disable iff (!nrst)
        (upper_d != upper_q) |=> !playback_valid [*8];
    endproperty
    a_surf_settle: assert property (p_surf_settle) else $error("playback valid early");

    property p_zero_flag;
        @(posedge clock) disable iff (!nrst)
        (sel && track_q == TRACK_ZERO) ##1 (sel && track_q == TRACK_ZERO)
        |-> !outermost_n;
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("track zero flag missing");

    property p_sel_valid;
        @(posedge clock) disable iff (!nrst)
        $fell(host_in.sel_n) ##0 (host_in.sel_n == 1'b0) [*5]
        |-> (media_lock_n == !hole_open) || $changed(hole_open);
    endproperty
    a_sel_valid: assert property (p_sel_valid) else $error("flag not valid after select");

    property p_spin_drop;
        @(posedge clock) disable iff (!nrst)
        !spin |=> !spindle_ready;
    endproperty
    a_spin_drop: assert property (p_spin_drop) else $error("spindle ready without run");

endmodule
`default_nettype wire

// *** hw/fdp_pkg.sv ***
// Package with constants and carrier types for the floppy drive host signal port
package fdp_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ           = 10_000_000;
    localparam int SEL_VALID_NS     = 500;      // Longest select-to-valid time
    localparam int SPIN_UP_MS       = 480;      // Longest spin-up time
    localparam int SEEK_SETTLE_MS   = 18;       // Longest move plus settle time
    localparam int SURF_SETTLE_US   = 100;      // Least surface settle time
    // Longest times round down, least times round up
    localparam int SEL_VALID_CYC    = (SEL_VALID_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int SPIN_UP_CYC      = SPIN_UP_MS * (CLK_HZ / 1000);
    localparam int SEEK_SETTLE_CYC  = SEEK_SETTLE_MS * (CLK_HZ / 1000);
    localparam int SURF_SETTLE_CYCI = (SURF_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int SPIN_W  = 23;
    localparam int SEEK_W  = 18;
    localparam int SURF_W  = 10;
    localparam int TRACK_W = 7;
    localparam int HOST_W  = 7;
    localparam logic [SURF_W-1:0]  SURF_SETTLE_CYC = SURF_W'(SURF_SETTLE_CYCI);
    localparam logic [TRACK_W-1:0] TRACK_ZERO      = 7'h00;
    localparam logic [TRACK_W-1:0] TRACK_INNER     = 7'h51;   // Track 81
    localparam logic [HOST_W-1:0]  HOST_IDLE       = 7'h7F;   // All lines false

    // ------------------------------------------------------------------
    // Carrier and state types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sel_n;     // Unit select, low true
        logic spin_n;    // Spindle run, low true
        logic dir;       // Head direction, high outward
        logic step_n;    // Step pulse, low true
        logic gate_n;    // Record gate, low true
        logic rec_n;     // Record pulse, low true
        logic surf;      // Surface select, high side 0
    } fdp_host_in_type;

    typedef enum logic [1:0] {
        SP_STOP  = 2'b00,
        SP_ACCEL = 2'b01,
        SP_RUN   = 2'b10
    } fdp_spin_state_type;

endpackage

// *** hw/fdp_sync.sv ***
// Two-stage synchroniser for the host input lines
`timescale 1ns/100ps
`default_nettype none
module fdp_sync
    import fdp_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic [HOST_W-1:0] async_in,
    output logic      [HOST_W-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Per-bit flop pairs
    // ------------------------------------------------------------------
    // Reset to the idle level so nothing looks asserted at power up
    for (genvar i = 0; i < HOST_W; i++) begin : g_bit
        logic meta_q;
        logic sync_q;
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                meta_q <= HOST_IDLE[i];
                sync_q <= HOST_IDLE[i];
            end else begin
                meta_q <= async_in[i];
                sync_q <= meta_q;
            end
        end
        assign sync_out[i] = sync_q;
    end

endmodule
`default_nettype wire

// *** testbench/fdp_host_model.sv ***
// Host controller model that drives the select, spindle, step and record lines
`timescale 1ns/100ps
`default_nettype none
module fdp_host_model
    import fdp_pkg::*;
#(
    parameter int GAP    = 60,    // Step spacing, scaled down with the settle count
    parameter int SETTLE = 1010,  // Wait before gating, covers seek and surface settle
    parameter int HOLD   = 6500   // Quiet time after releasing the gate
) (
    input  wire logic             clock,
    output var  fdp_host_in_type  host
);
    // ------------------------------------------------------------------
    // Line drivers
    // ------------------------------------------------------------------
    // All lines idle high, so nothing is asserted before the first task call
    initial host = fdp_host_in_type'(HOST_IDLE);

    // Level lines: a true select or spindle request drives its line low; the surface line is driven at lvl as given
    task automatic set_sel(input logic on);
        @(posedge clock);
        host.sel_n <= ~on;
    endtask

    task automatic set_spin(input logic on);
        @(posedge clock);
        host.spin_n <= ~on;
    endtask

    task automatic set_surf(input logic lvl);
        @(posedge clock);
        host.surf <= lvl;
    endtask

    // Gate waits on the way in and holds everything still on the way out
    task automatic set_gate(input logic on);
        if (on) repeat (SETTLE) @(posedge clock);
        @(posedge clock);
        host.gate_n <= ~on;
        if (!on) repeat (HOLD) @(posedge clock);
    endtask

    // One gap serves both directions; the scaled settle is far shorter anyway
    task automatic step(input logic outward);
        @(posedge clock);
        host.dir <= outward;
        repeat (10) @(posedge clock); // Direction settled 1us before the fall
        host.step_n <= 1'b0;
        repeat (10) @(posedge clock); // Low for 1us
        host.step_n <= 1'b1;
        repeat (GAP) @(posedge clock);
    endtask

    // Record pulse of 0.5us, then idle high until the next one
    task automatic rec();
        @(posedge clock);
        host.rec_n <= 1'b0;
        repeat (5) @(posedge clock);
        host.rec_n <= 1'b1; // Left idle while not writing
        repeat (5) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// *** testbench/test_fdp_port.sv ***
// Self-checking testbench for the drive-side host signal port
`timescale 1ns/100ps
`default_nettype none
module test_fdp_port;
    import fdp_pkg::*;
    localparam int SPIN_N = 50;
    localparam int SEEK_N = 40;
    logic                clock;
    logic                nrst;
    logic                hole_open;
    fdp_host_in_type     host_in;
    logic                outermost_n, media_lock_n, spindle_on, spindle_ready;
    logic                head_step, head_outward, seek_busy, write_mode;
    logic                rec_event, head_upper, playback_valid;
    logic [TRACK_W-1:0]  track;
    int                  error_cnt = 0, n_checks = 0, cyc = 0, seed, i, n;
    int                  trk = 0, sel_x = 0, gate_x = 0, steps_exp = 0, recs_exp = 0;
    int                  steps_seen = 0, recs_seen = 0, busy_len = 0;

    // ------------------------------------------------------------------
    // Design, host model and clock
    // ------------------------------------------------------------------
    fdp_port #(.SPIN_UP_CNT(SPIN_W'(SPIN_N)), .SEEK_CNT(SEEK_W'(SEEK_N))) uut (
        .clock(clock), .nrst(nrst), .host_in(host_in), .hole_open(hole_open),
        .outermost_n(outermost_n), .media_lock_n(media_lock_n), .spindle_on(spindle_on),
        .spindle_ready(spindle_ready), .head_step(head_step), .head_outward(head_outward),
        .track(track), .seek_busy(seek_busy), .write_mode(write_mode),
        .rec_event(rec_event), .head_upper(head_upper), .playback_valid(playback_valid)
    );
    fdp_host_model host_m (.clock(clock), .host(host_in));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Pulse counters and busy length; a hang is cut short by the cycle ceiling
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (head_step === 1'b1) steps_seen <= steps_seen + 1;
        if (rec_event === 1'b1) recs_seen <= recs_seen + 1;
        if (head_step === 1'b1) busy_len <= 1;
        else if (seek_busy === 1'b1) busy_len <= busy_len + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        @(negedge clock);
    endtask

    // Reference model of one step: accepted or ignored, then track moves
    task automatic do_step(input int dir);
        logic ok;
        ok = sel_x != 0 && !(gate_x != 0 && !hole_open) && !(trk == 0 && dir == 1)
             && !(trk == 81 && dir == 0);
        host_m.step(dir[0]);
        if (ok) begin
            steps_exp++;
            trk = dir != 0 ? trk - 1 : trk + 1;
        end
        @(negedge clock);
        check(steps_seen, steps_exp);
        check(track, trk);
        check(outermost_n, trk != 0 || sel_x == 0);
        if (ok) check(head_outward, dir);
        if (ok) check(busy_len, SEEK_N);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 82335;
        nrst = 1'b0;
        hole_open = 1'b0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        check({outermost_n, media_lock_n, spindle_on, spindle_ready, head_step,
               head_outward}, 6'h31);
        check({track, write_mode, rec_event, head_upper}, 10'h000);
        // Select: flags valid well inside 0.5us
        sel_x = 1;
        host_m.set_sel(sel_x[0]);
        settle(4);
        check(outermost_n, 1'b0);
        check(media_lock_n, 1'b1);
        @(posedge clock) hole_open <= 1'b1;
        settle(2);
        check(media_lock_n, 1'b0);
        @(posedge clock) hole_open <= 1'b0;
        // Spindle: ready no sooner than the spin-up count, and soon after it
        host_m.set_spin(1'b1);
        n = 0;
        while (spindle_ready !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check(n >= SPIN_N && n <= SPIN_N + 5, 1'b1);
        check(spindle_on, 1'b1);
        host_m.set_spin(1'b0);
        settle(4);
        check({spindle_on, spindle_ready}, 2'h0);
        // Steps: outward at track zero, inward past the inner limit, then random
        do_step(1);
        for (i = 0; i < 82; i++) do_step(0);
        for (i = 0; i < 20; i++) do_step($random(seed) & 1);
        // Writing: gate on unlocked media, pulses counted, steps ignored
        gate_x = 1;
        host_m.set_gate(gate_x[0]);
        settle(3);
        check(write_mode, 1'b1);
        n = ($random(seed) & 7) + 1;
        repeat (n) host_m.rec();
        recs_exp += n;
        do_step(0);
        check(recs_seen, recs_exp);
        // Locked media: no write mode, pulses dropped, steps accepted again
        @(posedge clock) hole_open <= 1'b1;
        repeat (4) host_m.rec();
        check(write_mode, 1'b0);
        check(recs_seen, recs_exp);
        do_step(1);
        gate_x = 0;
        host_m.set_gate(gate_x[0]);
        @(posedge clock) hole_open <= 1'b0;
        repeat (2) host_m.rec();
        check(recs_seen, recs_exp);
        // Surface: side 1 on a low level, playback checked still off at 99us, valid by 102us
        host_m.set_surf(1'b0);
        settle(4);
        check(head_upper, 1'b1);
        check(playback_valid, 1'b0);
        settle(990);
        check(playback_valid, 1'b0);
        settle(20);
        check(playback_valid, 1'b1);
        // Deselected: surface and steps have no effect
        sel_x = 0;
        host_m.set_sel(sel_x[0]);
        host_m.set_surf(1'b1);
        settle(5);
        check(head_upper, 1'b1);
        do_step(0);
        results();
    end
endmodule
`default_nettype wire
